// ==== psc_pkg.sv ====
`default_nettype none
package psc_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int RESULT_W   = 24;
    localparam int WORD_W     = 16;
    localparam int PROM_DEPTH = 8;
    localparam int CNT_W      = 24;

    // ------------------------------------------------------------------
    // Command bytes and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_RESET     = 8'h1e;
    localparam logic [7:0] CMD_ADC_READ  = 8'h00;
    localparam logic [3:0] CMD_CONV_P_HI = 4'h4;
    localparam logic [3:0] CMD_CONV_T_HI = 4'h5;
    localparam logic [3:0] CMD_PROM_HI   = 4'ha;
    localparam logic [2:0] OSR_MAX       = 3'h4;
    localparam logic [5:0] I2C_ADDR_HI   = 6'h3b;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK_I2C   = 4'h8;
    localparam logic [3:0] BIT_FIRST     = 4'h1;

    // ------------------------------------------------------------------
    // Conversion timing at the smallest ratio; doubles per ratio step
    // ------------------------------------------------------------------
    localparam int CLK_SYS_MHZ      = 50;
    localparam int CONV_TIME_256_US = 500;
    localparam int CONV_CYC_256     = CONV_TIME_256_US * CLK_SYS_MHZ;

    // Word 0 setup, words 1-6 coefficients, word 7 serial and check nibble
    // (arbitrary contents)
    localparam logic [127:0] PROM_IMAGE_DFLT =
        128'h5a3c_1e2d_9c75_5af0_82b8_5b0f_8fbf_0001;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ADDR  = 2'b01,
        ST_WRITE = 2'b11,
        ST_READ  = 2'b10
    } psc_state_t;

    typedef struct packed {
        logic       is_temp;
        logic [2:0] oversampling_ratio;
    } psc_conv_req_t;
endpackage
`default_nettype wire

// ==== psc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,   // Destination clock
    input  wire logic             rst_n_in, // Async reset, active low
    input  wire logic [WIDTH-1:0] d_in,     // Foreign level
    output logic      [WIDTH-1:0] q_out     // Synchronised level
);
    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("psc_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= '0;
            q_out  <= '0;
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== psc_conv_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module psc_conv_engine import psc_pkg::*; #(
    parameter int CYC_256 = CONV_CYC_256,
    parameter int CW      = CNT_W
) (
    input  wire logic                clk_in,      // System clock
    input  wire logic                rst_n_in,    // Async reset, active low
    input  wire logic                start_tgl_in,// Start toggle, link side
    input  wire psc_conv_req_t       req_in,      // Held while toggle moves
    input  wire logic [RESULT_W-1:0] press_in,    // Pressure sample
    input  wire logic [RESULT_W-1:0] temp_in,     // Temperature sample
    output logic                     busy_out,    // Conversion running
    output logic                     done_tgl_out,// Flips on completion
    output logic [RESULT_W-1:0]      result_out   // Stable after done
);
    logic          start_sync;
    logic          start_seen_q;
    logic          is_temp_q;
    logic [CW-1:0] cnt_q;

    if (CYC_256 < 1 || CW > 30 || (CYC_256 * 16) >= (1 << CW)) begin : g_chk
        $error("psc_conv_engine: CYC_256 does not fit the counter");
    end

    psc_sync #(.WIDTH(1)) u_start_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (start_tgl_in),
        .q_out    (start_sync)
    );

    // ------------------------------------------------------------------
    // Conversion runs here, so the link may stop or deselect meanwhile
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            start_seen_q <= 1'b0;
            busy_out     <= 1'b0;
            is_temp_q    <= 1'b0;
            cnt_q        <= '0;
            done_tgl_out <= 1'b0;
            result_out   <= '0;
        end else begin
            start_seen_q <= start_sync;
            if (start_sync != start_seen_q) begin
                busy_out  <= 1'b1;
                is_temp_q <= req_in.is_temp;
                cnt_q     <= CW'(CYC_256) << req_in.oversampling_ratio;
            end else if (busy_out) begin
                cnt_q <= cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    busy_out     <= 1'b0;
                    done_tgl_out <= ~done_tgl_out;
                    result_out   <= is_temp_q ? temp_in : press_in;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ==== psc_serial_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Reset command after power-up loads calibration image into registers.
// - Reset command at any later time returns memory logic to known state.
// - Conversion command starts pressure or temperature; runs on if deselected.
// - ADC read after a conversion shifts the result out MSB first.
// - ADC read with no conversion since last read returns zero.
// - ADC read during conversion returns zero and spoils that result.
// - Calibration memory is eight words, 128 bits in all.
// - Word 0 setup, words 1-6 coefficients, word 7 serial and check.
// - Calibration read is one byte; answer is 16 bits MSB first.
// - I2C address is 111011 then inverse of chip select.
// - In I2C mode a reset command is taken at any time.
// - After a conversion command the device stays busy until done.
// - I2C result read is 24 bits, acknowledged every 8 bits.
// - Calibration memory holds a 4-bit check code.
// - Command byte encodings for reset, conversions, ADC and PROM reads.
// - Protocol select low chooses SPI, high chooses I2C.
// - SPI accepts clock modes 0 and 3.
// - ADC read returns a 24-bit result.
module psc_serial_cmd import psc_pkg::*; #(
    parameter int           CONV_CYC = CONV_CYC_256,
    parameter logic [127:0] PROM_IMAGE = PROM_IMAGE_DFLT
) (
    input  wire logic                clk_sys_in,        // System clock
    input  wire logic                rst_n_in,          // Async reset, low
    input  wire logic                serial_clk_in,     // Host serial clock
    input  wire logic                protocol_select_in,// Low SPI, high I2C
    input  wire logic                chip_select_n_in,  // Chip select, low
    input  wire logic                serial_in_in,      // SPI data in
    input  wire logic                sda_in,            // I2C data level
    input  wire logic [RESULT_W-1:0] press_sample_in,   // Pressure sample
    input  wire logic [RESULT_W-1:0] temp_sample_in,    // Temperature sample
    output logic                     sda_out,           // I2C data value
    output logic                     sda_oe_out,        // I2C pulls low
    output logic                     serial_out_out,    // SPI data out
    output logic                     serial_out_oe_out, // SPI drives out
    output logic                     busy_out           // Conversion busy
);
    // ------------------------------------------------------------------
    // Link side declarations
    // ------------------------------------------------------------------
    logic [1:0]          strap_sync;
    logic                i2c_mode;
    logic                csn_level;
    logic                frame_rst_n;
    logic                done_sync;
    logic                eng_done_tgl;
    logic [RESULT_W-1:0] eng_result;

    psc_state_t          state_q;
    logic [3:0]          cnt_q;
    logic [6:0]          rx_q;
    logic                ack_q;
    logic                sda_hi_q;
    logic                start_q;

    logic [RESULT_W-1:0] tx_q;
    logic                conv_tgl_q;
    psc_conv_req_t       conv_req_q;
    logic                done_seen_q;
    logic [RESULT_W-1:0] result_q;
    logic                valid_q;
    logic                corrupt_q;
    logic [WORD_W-1:0]   calib_q [PROM_DEPTH];

    logic                din;
    logic [7:0]          byte_w;
    logic [3:0]          last_bit;
    logic                byte_end;
    logic                cmd_stb;
    logic                addr_hit;
    logic                cap;
    logic                busy_l;
    logic                is_reset;
    logic                is_conv;
    logic                is_adc;
    logic                is_prom;
    logic                val_now;
    logic [RESULT_W-1:0] res_now;

    // ------------------------------------------------------------------
    // Straps and crossings
    // ------------------------------------------------------------------
    // Straps are static; the first clocks after power-up flush them in
    psc_sync #(.WIDTH(2)) u_strap_sync (
        .clk_in   (serial_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({protocol_select_in, chip_select_n_in}),
        .q_out    (strap_sync)
    );

    psc_sync #(.WIDTH(1)) u_done_sync (
        .clk_in   (serial_clk_in),
        .rst_n_in (rst_n_in),
        .d_in     (eng_done_tgl),
        .q_out    (done_sync)
    );

    psc_conv_engine #(.CYC_256(CONV_CYC), .CW(CNT_W)) u_engine (
        .clk_in       (clk_sys_in),
        .rst_n_in     (rst_n_in),
        .start_tgl_in (conv_tgl_q),
        .req_in       (conv_req_q),
        .press_in     (press_sample_in),
        .temp_in      (temp_sample_in),
        .busy_out     (busy_out),
        .done_tgl_out (eng_done_tgl),
        .result_out   (eng_result)
    );

    assign i2c_mode  = strap_sync[1];
    assign csn_level = strap_sync[0];

    // SPI deselect clears the framing logic even with the clock stopped
    assign frame_rst_n = rst_n_in & (protocol_select_in | ~chip_select_n_in);

    // ------------------------------------------------------------------
    // Byte framing and command decode
    // ------------------------------------------------------------------
    always_comb begin
        din      = i2c_mode ? sda_in : serial_in_in;
        byte_w   = {rx_q, din};
        last_bit = i2c_mode ? BIT_ACK_I2C : BIT_LAST;
        byte_end = (cnt_q == BIT_LAST) && !start_q;
        cmd_stb  = byte_end && (state_q == ST_WRITE ||
                   (state_q == ST_IDLE && !i2c_mode));
        addr_hit = byte_w[7:1] == {I2C_ADDR_HI, ~csn_level};
        is_reset = byte_w == CMD_RESET;
        is_adc   = byte_w == CMD_ADC_READ;
        is_conv  = (byte_w[7:4] == CMD_CONV_P_HI ||
                    byte_w[7:4] == CMD_CONV_T_HI) &&
                   !byte_w[0] && byte_w[3:1] <= OSR_MAX;
        is_prom  = byte_w[7:4] == CMD_PROM_HI && !byte_w[0];
        cap      = done_sync != done_seen_q;
        busy_l   = conv_tgl_q != done_sync;
        val_now  = cap ? !corrupt_q : valid_q;
        res_now  = cap ? eng_result : result_q;
    end

    // ------------------------------------------------------------------
    // Bit engine: sample on rising edge in SPI modes 0 and 3 and I2C
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 4'h0;
            rx_q     <= 7'h00;
            ack_q    <= 1'b0;
            sda_hi_q <= 1'b1;
        end else begin
            sda_hi_q <= sda_in;
            rx_q     <= byte_w[6:0];
            ack_q    <= 1'b0;
            if (start_q) begin
                state_q <= ST_ADDR;
                cnt_q   <= BIT_FIRST;
            end else begin
                cnt_q <= (cnt_q == last_bit) ? 4'h0 : cnt_q + 4'h1;
                if (byte_end) begin
                    case (state_q)
                        ST_ADDR: begin
                            if (addr_hit) begin
                                ack_q   <= 1'b1;
                                state_q <= byte_w[0] ? ST_READ : ST_WRITE;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                        ST_WRITE: begin
                            ack_q <= 1'b1;
                        end
                        ST_IDLE: begin
                            if (!i2c_mode) begin
                                state_q <= ST_READ;
                            end
                        end
                        ST_READ: begin
                            state_q <= ST_READ;
                        end
                        default: begin
                            state_q <= ST_IDLE;
                        end
                    endcase
                end else if (i2c_mode && cnt_q == BIT_ACK_I2C &&
                             state_q == ST_READ && din) begin
                    // Host declined the next byte
                    state_q <= ST_IDLE;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Drive on falling edge; start seen as data falling while clock high
    // ------------------------------------------------------------------
    always_ff @(negedge serial_clk_in or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            start_q           <= 1'b0;
            sda_out           <= 1'b0;
            sda_oe_out        <= 1'b0;
            serial_out_out    <= 1'b0;
            serial_out_oe_out <= 1'b0;
        end else begin
            start_q           <= i2c_mode && sda_hi_q && !sda_in;
            sda_out           <= 1'b0;
            sda_oe_out        <= i2c_mode && (ack_q ||
                                 (state_q == ST_READ &&
                                  cnt_q != BIT_ACK_I2C && !tx_q[RESULT_W-1]));
            serial_out_out    <= tx_q[RESULT_W-1];
            serial_out_oe_out <= !i2c_mode;
        end
    end

    // ------------------------------------------------------------------
    // Answer shifter: loaded by a command, shifted while reading
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_q <= '0;
        end else if (cmd_stb) begin
            if (is_adc) begin
                tx_q <= (val_now && !busy_l) ? res_now : '0;
            end else if (is_prom) begin
                // Three address bits reach exactly the eight words
                tx_q <= {calib_q[byte_w[3:1]], 8'h00};
            end else begin
                tx_q <= '0;
            end
        end else if (state_q == ST_READ && cnt_q != BIT_ACK_I2C &&
                     !start_q) begin
            tx_q <= {tx_q[RESULT_W-2:0], 1'b0};
        end
    end

    // ------------------------------------------------------------------
    // Conversion request and result capture
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            conv_tgl_q  <= 1'b0;
            conv_req_q  <= '0;
            done_seen_q <= 1'b0;
            result_q    <= '0;
        end else begin
            if (cap) begin
                done_seen_q <= done_sync;
                result_q    <= eng_result;
            end
            // A start while busy is refused; the running result is spoilt
            if (cmd_stb && is_conv && !busy_l) begin
                conv_tgl_q         <= ~conv_tgl_q;
                conv_req_q.is_temp <= byte_w[4];
                conv_req_q.oversampling_ratio     <= byte_w[3:1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Result status: one read per conversion, spoilt results read zero
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            valid_q <= 1'b0;
        end else if (cmd_stb && (is_reset || is_adc ||
                                 (is_conv && !busy_l))) begin
            valid_q <= 1'b0;
        end else if (cap) begin
            valid_q <= !corrupt_q;
        end
    end

    always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            corrupt_q <= 1'b0;
        end else if (cmd_stb && is_conv && !busy_l) begin
            corrupt_q <= 1'b0;
        end else if (cmd_stb && busy_l && (is_reset || is_adc || is_conv)) begin
            corrupt_q <= 1'b1;
        end else if (cap) begin
            corrupt_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Calibration registers, filled from the image by a reset command
    // ------------------------------------------------------------------
    always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < PROM_DEPTH; i++) begin
                calib_q[i] <= '0;
            end
        end else if (cmd_stb && is_reset) begin
            // Word 7 low nibble carries the check code
            for (int i = 0; i < PROM_DEPTH; i++) begin
                calib_q[i] <= PROM_IMAGE[i*WORD_W +: WORD_W];
            end
        end
    end
endmodule
`default_nettype wire

// ==== psc_serial_cmd_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module psc_serial_cmd_properties #(
    parameter int CONV_CYC = 20
) (
    input wire logic clk_sys_in,         // System clock
    input wire logic rst_n_in,           // Async reset, low
    input wire logic serial_clk_in,      // Host serial clock
    input wire logic protocol_select_in, // Low SPI, high I2C
    input wire logic chip_select_n_in,   // Select or strap
    input wire logic sda_out,            // I2C data value
    input wire logic sda_oe_out,         // I2C pulls low
    input wire logic serial_out_out,     // SPI data
    input wire logic serial_out_oe_out,  // SPI drives
    input wire logic busy_out            // Conversion busy
);
    // ----------------------------------------------------------------
    // Busy run length and time since the serial clock was high
    // ----------------------------------------------------------------
    logic [31:0] run_q;
    logic [3:0]  age_q;
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q <= '0;
            age_q <= '0;
        end else begin
            run_q <= busy_out ? run_q + 32'h1 : '0;
            age_q <= serial_clk_in ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
        end
    end
    sequence s_run;
        busy_out [*8];
    endsequence
    // Only the five ratio lengths are legal
    sequence s_len;
        run_q == CONV_CYC || run_q == 2 * CONV_CYC || run_q == 4 * CONV_CYC
            || run_q == 8 * CONV_CYC || run_q == 16 * CONV_CYC;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    sda_zero_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) sda_out == 1'b0) else $error("sda value high");
    cs_release_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) chip_select_n_in [*2] |-> !serial_out_oe_out)
        else $error("spi output driven while deselected");
    i2c_quiet_a: assert property (@(posedge serial_clk_in)
        disable iff (!rst_n_in) protocol_select_in [*4] |-> !serial_out_oe_out)
        else $error("spi output driven in i2c mode");
    spi_quiet_a: assert property (@(posedge serial_clk_in)
        disable iff (!rst_n_in) !protocol_select_in [*4] |-> !sda_oe_out)
        else $error("sda pulled in spi mode");
    conv_min_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) $rose(busy_out) |-> s_run)
        else $error("busy ended early");
    conv_len_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) $fell(busy_out) |-> s_len)
        else $error("busy length wrong");
    shift_hold_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) (serial_clk_in && !chip_select_n_in) [*2]
        |-> $stable(serial_out_out)) else $error("spi data moved on high clock");
    busy_cause_a: assert property (@(posedge clk_sys_in)
        disable iff (!rst_n_in) $rose(busy_out) |-> age_q <= 4'h8)
        else $error("busy rose without a command");
endmodule
bind psc_serial_cmd psc_serial_cmd_properties #(.CONV_CYC(CONV_CYC)) u_props (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .serial_clk_in(serial_clk_in), .protocol_select_in(protocol_select_in),
    .chip_select_n_in(chip_select_n_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .serial_out_out(serial_out_out),
    .serial_out_oe_out(serial_out_oe_out), .busy_out(busy_out));
`default_nettype wire

// ==== psc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psc_host_model (
    output logic        sclk_out,  // Serial clock, still between frames
    output logic        cs_n_out,  // Select, or address strap in I2C
    output logic        mosi_out,  // Data to device
    output logic        sda_n_out, // Low pulls the data line
    input  wire logic   miso_in,   // Data from device
    input  wire logic   sda_in,    // Resolved data line
    output logic [23:0] rx_out,    // Last answer
    output logic        rx_t_out   // Flips per answer
);
    localparam int HALF = 32;
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
        sda_n_out = 1'b1;
        rx_out = '0;
        rx_t_out = 1'b0;
    end
    // Bus clear and strap sync clocks; select is left alone
    task automatic idle(input int k);
        repeat (2 * k) #HALF sclk_out = ~sclk_out;
    endtask
    task automatic spi(input logic m3, input logic [7:0] c, input int n);
        logic [23:0] r;
        r = '0;
        sclk_out = m3;
        #HALF cs_n_out = 1'b0;
        for (int i = 0; i < 8 + n; i++) begin
            #HALF sclk_out = 1'b0;
            mosi_out = i < 8 ? c[7 - i] : 1'b0;
            #HALF sclk_out = 1'b1;
            r = {r[22:0], miso_in};
        end
        #HALF sclk_out = m3;
        cs_n_out = 1'b1;
        mosi_out = ~mosi_out;
        if (n > 0) begin
            rx_out = r;
            rx_t_out = ~rx_t_out;
        end
    endtask
    // Address byte and one more; answer is the line at each rising edge
    task automatic i2c(input logic s, input logic [7:0] a, input logic [7:0] c);
        logic [17:0] b;
        logic [17:0] k;
        b = {a, 1'b1, c, 1'b1};
        k = '0;
        cs_n_out = s;
        idle(3);
        sclk_out = 1'b1;
        #HALF sda_n_out = 1'b0;
        #HALF sclk_out = 1'b0;
        for (int i = 17; i >= 0; i--) begin
            #4 sda_n_out = b[i];
            #(HALF - 4) sclk_out = 1'b1;
            k = {k[16:0], sda_in};
            #HALF sclk_out = 1'b0;
        end
        #4 sda_n_out = 1'b0;
        #HALF sclk_out = 1'b1;
        #HALF sda_n_out = 1'b1;
        rx_out = {6'h0, k};
        rx_t_out = ~rx_t_out;
    endtask
endmodule
`default_nettype wire

// ==== test_pressure_sensor_serial_cmd.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_pressure_sensor_serial_cmd;
    import psc_pkg::*;
    // Arbitrary calibration image with distinct words
    localparam logic [127:0] IMG = 128'h7e11_6d22_5c33_4b44_3a55_2966_1877_0f88;
    logic        clk_sys, rst_n, ps, sclk, cs_n, mosi, sda_n, miso, sda;
    logic        rx_t, sda_o, sda_oe, so, so_oe, busy;
    logic [23:0] press, temp, rx;
    logic [23:0] exp_q[$];
    int          fails = 0;
    int          checked = 0;
    assign sda = sda_n & (sda_oe ? sda_o : 1'b1);
    assign miso = so_oe ? so : ~so;
    psc_serial_cmd #(.CONV_CYC(20), .PROM_IMAGE(IMG)) dut (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .serial_clk_in(sclk),
        .protocol_select_in(ps), .chip_select_n_in(cs_n), .serial_in_in(mosi),
        .sda_in(sda), .press_sample_in(press), .temp_sample_in(temp),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .serial_out_out(so),
        .serial_out_oe_out(so_oe), .busy_out(busy));
    psc_host_model host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
        .sda_n_out(sda_n), .miso_in(miso), .sda_in(sda), .rx_out(rx),
        .rx_t_out(rx_t));
    // ----------------------------------------------------------------
    // Checking and closing
    // ----------------------------------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] want);
        checked++;
        if (got !== want) begin
            fails++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, want);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic rd(input logic m3, input logic [7:0] c, input logic [23:0] e);
        exp_q.push_back(e);
        host.spi(m3, c, 24);
    endtask
    task automatic wait_busy(input logic v);
        for (int i = 0; i < 1000 && busy !== v; i++) @(negedge clk_sys);
        check({23'h0, busy}, {23'h0, v});
    endtask
    always @(rx_t) begin
        if ($time > 0) check(rx, exp_q.pop_front());
    end
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #1ms;
        fails++;
        close_out();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic       t;
        logic [2:0] o;
        rst_n = 1'b0;
        ps = 1'b0;
        press = '0;
        temp = '0;
        void'($urandom(32'h55e6));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        host.idle(3);
        rd(1'b0, 8'ha2, 24'h0);
        host.spi(1'b0, CMD_RESET, 0);
        for (int i = 0; i < 8; i++) begin
            rd(i[0], {CMD_PROM_HI, i[2:0], 1'b0}, {IMG[16*i +: 16], 8'h00});
        end
        rd(1'b1, CMD_ADC_READ, 24'h0);
        for (int k = 0; k < 10; k++) begin
            t = k[0];
            o = 3'(k / 2);
            @(posedge clk_sys);
            press <= 24'($urandom);
            temp <= 24'($urandom);
            host.spi(k[1], {t ? CMD_CONV_T_HI : CMD_CONV_P_HI, o, 1'b0}, 0);
            wait_busy(1'b1);
            wait_busy(1'b0);
            host.idle(3);
            rd(k[1], CMD_ADC_READ, t ? temp : press);
            rd(k[0], CMD_ADC_READ, 24'h0);
        end
        host.spi(1'b0, 8'h48, 0);
        wait_busy(1'b1);
        rd(1'b0, CMD_ADC_READ, 24'h0);
        wait_busy(1'b0);
        host.idle(3);
        rd(1'b0, CMD_ADC_READ, 24'h0);
        host.spi(1'b0, 8'h4a, 0);
        repeat (6) @(negedge clk_sys);
        check({23'h0, busy}, 24'h0);
        @(posedge clk_sys);
        ps <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            exp_q.push_back({6'h0, I2C_ADDR_HI, s[0], 1'b0, s[0] == s[1],
                CMD_RESET, s[0] == s[1]});
            host.i2c(s[1], {I2C_ADDR_HI, s[0], 1'b0}, CMD_RESET);
        end
        exp_q.push_back({6'h0, I2C_ADDR_HI, 3'b100, CMD_PROM_HI, 5'h0c});
        host.i2c(1'b0, {I2C_ADDR_HI, 2'b10}, {CMD_PROM_HI, 4'h6});
        exp_q.push_back({6'h0, I2C_ADDR_HI, 3'b110, IMG[63:56], 1'b1});
        host.i2c(1'b0, {I2C_ADDR_HI, 2'b11}, 8'hff);
        #1us;
        check(24'(exp_q.size()), 24'h0);
        close_out();
    end
endmodule
`default_nettype wire
